// file: rtl/cicp_channel.sv
`include "cicp_params.svh"

module cicp_channel #(
  parameter bit FOUR_TO_20 = 1'b0,
  parameter bit FILTER_AVAIL = 1'b1
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Converter samples
  input wire logic sample_valid_in,
  input wire logic [15:0] sample_in,
  // Register mode access
  input wire cicp_pkg::cicp_reg_req_s reg_in,
  output logic reg_ack_out,
  output logic [15:0] reg_rdata_out,
  // Process data
  output logic pv_valid_out,
  output logic [15:0] pv_out,
  output cicp_pkg::cicp_status_s status_out,
  // Converter control
  output logic [15:0] adc_offset_out,
  output logic watchdog_en_out
);

  logic [15:0] raw_ff, prev_ff, hw_off_ff, hw_gain_ff, f_off_ff, f_gain_ff;
  logic [15:0] upper_ff, lower_ff, preset_ff, code_ff, feature_ff;
  logic [15:0] u_off_ff, u_gain_ff, lim1_ff, lim2_ff, nxt_rdata;
  logic loaded_ff, unlocked, prot, wr_ok;
  logic [16:0] filt_sum;
  logic [15:0] filt, vc, nvc, fv;
  logic over, under, sie_ovf, sie_err;
  cicp_pkg::cicp_wide_t v;
  cicp_pkg::cicp_status_s nxt_status;

  function automatic cicp_pkg::cicp_wide_t sx(input logic [15:0] x);
    return {{32{x[15]}}, x};
  endfunction

  function automatic cicp_pkg::cicp_wide_t ux(input logic [15:0] x);
    return {32'h0000_0000, x};
  endfunction

  function automatic logic [1:0] lim_code(input logic en, input logic [15:0] val,
                                          input logic [15:0] lim);
    if (!en) begin
      return `CICP_LIM_OFF;
    end else if ($signed(val) < $signed(lim)) begin
      return `CICP_LIM_BELOW;
    end else if ($signed(val) > $signed(lim)) begin
      return `CICP_LIM_ABOVE;
    end else begin
      return `CICP_LIM_EQUAL;
    end
  endfunction

  assign unlocked = (code_ff == `CICP_CODEWORD);
  assign prot = (reg_in.addr >= `CICP_A_PROT_LO) && (reg_in.addr <= `CICP_A_PROT_HI)
                && (reg_in.addr != `CICP_A_CODE);
  assign wr_ok = ce_in && reg_in.req && reg_in.wr && prot && unlocked;

  // Filter averages two samples; absent on variants without it
  assign filt_sum = {sample_in[15], sample_in} + {prev_ff[15], prev_ff};
  assign filt = (FILTER_AVAIL && feature_ff[`CICP_FB_FILT]) ? filt_sum[16:1] : sample_in;

  // Processing chain
  always_comb begin
    v = ((sx(filt) + sx(hw_off_ff)) * ux(hw_gain_ff)) >>> `CICP_SH_HW;
    if (feature_ff[`CICP_FB_FACT]) begin
      v = ((v * sx(f_gain_ff)) >>> `CICP_SH_F) + sx(f_off_ff);
    end
    if (feature_ff[`CICP_FB_USER]) begin
      v = ((v * sx(u_gain_ff)) >>> `CICP_SH_U) + sx(u_off_ff);
    end
    over = 1'b0;
    under = 1'b0;
    if (feature_ff[`CICP_FB_CLIP]) begin
      if (v > sx(upper_ff)) begin
        over = 1'b1;
        vc = upper_ff;
      end else if (v < sx(lower_ff)) begin
        under = 1'b1;
        vc = lower_ff;
      end else begin
        vc = v[15:0];
      end
    end else if (v > sx(16'h7FFF)) begin
      // Without clipping, saturate rather than wrap
      vc = 16'h7FFF;
    end else if (v < sx(16'h8000)) begin
      vc = 16'h8000;
    end else begin
      vc = v[15:0];
    end
  end

  // Status and output format
  always_comb begin
    nxt_status = '0;
    nxt_status.over = over;
    nxt_status.under = under;
    nxt_status.error = over | under;
    nxt_status.lim1 = lim_code(feature_ff[`CICP_FB_LIM1], vc, lim1_ff);
    nxt_status.lim2 = lim_code(feature_ff[`CICP_FB_LIM2], vc, lim2_ff);
    nvc = ~vc + 16'h0001;
    fv = vc;
    if (feature_ff[`CICP_FB_SIGNMAG] && vc[15]) begin
      fv = {1'b1, nvc[14:0]};
    end
    sie_ovf = over | (FOUR_TO_20 & under);
    sie_err = FOUR_TO_20 & under & feature_ff[`CICP_FB_BREAK];
    if (feature_ff[`CICP_FB_EMBED]) begin
      fv = {fv[15:3], 1'b0, sie_err, sie_ovf};
    end
  end

  // Sample capture
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      raw_ff <= 16'h0000;
      prev_ff <= 16'h0000;
    end else if (ce_in && sample_valid_in) begin
      raw_ff <= sample_in;
      prev_ff <= sample_in;
    end
  end

  // Processed output
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pv_valid_out <= 1'b0;
      pv_out <= 16'h0000;
      status_out <= '0;
    end else if (ce_in) begin
      pv_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        pv_out <= fv;
        status_out <= nxt_status;
      end
    end
  end

  // Converter offset taken from preset once after reset
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      loaded_ff <= 1'b0;
      adc_offset_out <= 16'h0000;
    end else if (ce_in && !loaded_ff) begin
      loaded_ff <= 1'b1;
      adc_offset_out <= preset_ff;
    end
  end

  // Code word lives in RAM: never protected itself
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      code_ff <= 16'h0000;
    end else if (ce_in && reg_in.req && reg_in.wr && reg_in.addr == `CICP_A_CODE) begin
      code_ff <= reg_in.wdata;
    end
  end

  // Parameter registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hw_off_ff <= `CICP_RST_HW_OFF;
      hw_gain_ff <= `CICP_RST_HW_GAIN;
      f_off_ff <= `CICP_RST_F_OFF;
      f_gain_ff <= `CICP_RST_F_GAIN;
      upper_ff <= `CICP_RST_UPPER;
      lower_ff <= `CICP_RST_LOWER;
      preset_ff <= `CICP_RST_PRESET;
      feature_ff <= `CICP_RST_FEATURE;
      u_off_ff <= `CICP_RST_U_OFF;
      u_gain_ff <= `CICP_RST_U_GAIN;
      lim1_ff <= `CICP_RST_LIM;
      lim2_ff <= `CICP_RST_LIM;
    end else if (wr_ok) begin
      case (reg_in.addr)
        `CICP_A_HW_OFF: hw_off_ff <= reg_in.wdata;
        `CICP_A_HW_GAIN: hw_gain_ff <= reg_in.wdata;
        `CICP_A_F_OFF: f_off_ff <= reg_in.wdata;
        `CICP_A_F_GAIN: f_gain_ff <= reg_in.wdata;
        `CICP_A_UPPER: upper_ff <= reg_in.wdata;
        `CICP_A_LOWER: lower_ff <= reg_in.wdata;
        `CICP_A_PRESET: preset_ff <= reg_in.wdata;
        // Reserved and break bits are stored as written; software keeps them
        `CICP_A_FEATURE: feature_ff <= reg_in.wdata;
        `CICP_A_U_OFF: u_off_ff <= reg_in.wdata;
        `CICP_A_U_GAIN: u_gain_ff <= reg_in.wdata;
        `CICP_A_LIM1: lim1_ff <= reg_in.wdata;
        `CICP_A_LIM2: lim2_ff <= reg_in.wdata;
        default: ;
      endcase
    end
  end

  assign watchdog_en_out = feature_ff[`CICP_FB_WDOG];

  // Read mux
  always_comb begin
    case (reg_in.addr)
      `CICP_A_RAW: nxt_rdata = raw_ff;
      `CICP_A_DIAG: nxt_rdata = {8'h00, status_out};
      `CICP_A_HW_OFF: nxt_rdata = hw_off_ff;
      `CICP_A_HW_GAIN: nxt_rdata = hw_gain_ff;
      `CICP_A_F_OFF: nxt_rdata = f_off_ff;
      `CICP_A_F_GAIN: nxt_rdata = f_gain_ff;
      `CICP_A_UPPER: nxt_rdata = upper_ff;
      `CICP_A_LOWER: nxt_rdata = lower_ff;
      `CICP_A_PRESET: nxt_rdata = preset_ff;
      `CICP_A_CODE: nxt_rdata = unlocked ? code_ff : 16'h0000;
      `CICP_A_FEATURE: nxt_rdata = feature_ff;
      `CICP_A_U_OFF: nxt_rdata = u_off_ff;
      `CICP_A_U_GAIN: nxt_rdata = u_gain_ff;
      `CICP_A_LIM1: nxt_rdata = lim1_ff;
      `CICP_A_LIM2: nxt_rdata = lim2_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Bus answer one cycle after the request
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_ack_out <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      reg_ack_out <= reg_in.req;
      if (reg_in.req) begin
        reg_rdata_out <= nxt_rdata;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence seq_code_wr;
    ce_in && reg_in.req && reg_in.wr && reg_in.addr == `CICP_A_CODE
      && reg_in.wdata == `CICP_CODEWORD;
  endsequence

  sequence seq_feat_wr_after;
    ce_in && reg_in.req && reg_in.wr && reg_in.addr == `CICP_A_FEATURE;
  endsequence

  AST_RAW_CAPTURE: assert property (
    ce_in && sample_valid_in |=> raw_ff == $past(sample_in))
    else $error("raw sample not captured");

  AST_DIAG_LAYOUT: assert property (
    ce_in && reg_in.req && reg_in.addr == `CICP_A_DIAG
      |=> reg_rdata_out == {8'h00, $past(status_out)})
    else $error("diagnostic register layout wrong");

  AST_CODE_UNLOCK: assert property (
    seq_code_wr |=> unlocked)
    else $error("code word did not unlock");

  // Host leaves idle cycles between requests, so the unlock is a level, not a pair
  AST_UNLOCK_THEN_WRITE: assert property (
    unlocked and seq_feat_wr_after |=> feature_ff == $past(reg_in.wdata))
    else $error("unlocked feature write not taken");

  AST_LOCKED_WRITE: assert property (
    (!unlocked) and seq_feat_wr_after |=> $stable(feature_ff))
    else $error("write accepted while protected");

  AST_CLIP_HIGH: assert property (
    ce_in && sample_valid_in && over && feature_ff[4:3] == 2'b00
      |=> pv_out == $past(upper_ff) && status_out.over && status_out.error)
    else $error("upper clip not applied");

  AST_CLIP_LOW: assert property (
    ce_in && sample_valid_in && under && feature_ff[4:3] == 2'b00
      |=> pv_out == $past(lower_ff) && status_out.under)
    else $error("lower clip not applied");

  AST_SIGNMAG: assert property (
    ce_in && sample_valid_in && vc == 16'hFFFF && feature_ff[4:3] == 2'b01
      |=> pv_out == 16'h8001)
    else $error("sign-magnitude of minus one wrong");

  AST_LIM1_OFF: assert property (
    ce_in && sample_valid_in && !feature_ff[`CICP_FB_LIM1] |=> status_out.lim1 == 2'b00)
    else $error("inactive limit one not coded zero");

  AST_LIM1_ABOVE: assert property (
    ce_in && sample_valid_in && feature_ff[`CICP_FB_LIM1] && $signed(vc) > $signed(lim1_ff)
      |=> status_out.lim1 == 2'b10)
    else $error("limit one above not reported");

  AST_EMBED_BIT2: assert property (
    ce_in && sample_valid_in && feature_ff[`CICP_FB_EMBED]
      |=> pv_out[2] == 1'b0 && pv_out[0] == $past(sie_ovf))
    else $error("embedded status bits wrong");

  AST_BREAK: assert property (
    ce_in && sample_valid_in && FOUR_TO_20 && under && feature_ff[`CICP_FB_EMBED]
      && feature_ff[`CICP_FB_BREAK] |=> pv_out[1:0] == 2'b11)
    else $error("wire breakage not embedded");

endmodule // cicp_channel

// file: rtl/cicp_params.svh
`ifndef CICP_PARAMS_SVH
`define CICP_PARAMS_SVH

// Register indices on the 6-bit register-mode address
`define CICP_A_RAW 6'h00
`define CICP_A_DIAG 6'h06
`define CICP_A_HW_OFF 6'h11
`define CICP_A_HW_GAIN 6'h12
`define CICP_A_F_OFF 6'h13
`define CICP_A_F_GAIN 6'h14
`define CICP_A_UPPER 6'h15
`define CICP_A_LOWER 6'h16
`define CICP_A_PRESET 6'h17
`define CICP_A_CODE 6'h1F
`define CICP_A_FEATURE 6'h20
`define CICP_A_U_OFF 6'h21
`define CICP_A_U_GAIN 6'h22
`define CICP_A_LIM1 6'h23
`define CICP_A_LIM2 6'h24
// Write-protected window
`define CICP_A_PROT_LO 6'h10
`define CICP_A_PROT_HI 6'h2F

// Reset values
`define CICP_RST_HW_OFF 16'h0000
`define CICP_RST_HW_GAIN 16'h1000
`define CICP_RST_F_OFF 16'h0000
`define CICP_RST_F_GAIN 16'h2002
`define CICP_RST_UPPER 16'h0FFF
`define CICP_RST_LOWER 16'h0000
`define CICP_RST_PRESET 16'h0000
`define CICP_RST_FEATURE 16'h1106
`define CICP_RST_U_OFF 16'h0000
`define CICP_RST_U_GAIN 16'h0100
`define CICP_RST_LIM 16'h0000
`define CICP_CODEWORD 16'h1235

// Fixed-point shifts of the gain registers
`define CICP_SH_HW 12
`define CICP_SH_F 10
`define CICP_SH_U 8

// Feature bit positions
`define CICP_FB_USER 0
`define CICP_FB_FACT 1
`define CICP_FB_WDOG 2
`define CICP_FB_SIGNMAG 3
`define CICP_FB_EMBED 4
`define CICP_FB_CLIP 8
`define CICP_FB_LIM1 9
`define CICP_FB_LIM2 10
`define CICP_FB_FILT 11
`define CICP_FB_BREAK 12

// Limit comparison codes
`define CICP_LIM_OFF 2'h0
`define CICP_LIM_BELOW 2'h1
`define CICP_LIM_ABOVE 2'h2
`define CICP_LIM_EQUAL 2'h3

`endif

// file: rtl/cicp_pkg.sv
package cicp_pkg;

  typedef logic signed [47:0] cicp_wide_t;

  // Status byte, msb first
  typedef struct packed {
    logic zero7;
    logic error;
    logic [1:0] lim2;
    logic [1:0] lim1;
    logic over;
    logic under;
  } cicp_status_s;

  // One register-mode request
  typedef struct packed {
    logic req;
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } cicp_reg_req_s;

endpackage

// file: test/cicp_host_model.sv
// Bus coupler side: issues one register-mode request at a time
module cicp_host_model (
  // Clock
  input wire logic core_clk_in,
  // Register mode
  output cicp_pkg::cicp_reg_req_s reg_out,
  input wire logic reg_ack_in,
  input wire logic [15:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial reg_out = '0;

  // Request is a one-cycle pulse; ack and data are taken at the edge after it
  task automatic access(input logic wr, input logic [5:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ok);
    @(posedge core_clk_in);
    #1;
    reg_out = {1'b1, wr, addr, wdata};
    @(posedge core_clk_in);
    #1;
    ok = reg_ack_in;
    rdata = reg_rdata_in;
    // Released data is scrambled so that a stale latch cannot look correct
    reg_out = {1'b0, 1'b0, ~addr, ~wdata};
  endtask
endmodule // cicp_host_model

// file: test/current_input_channel_processing_test.sv
module current_input_channel_processing_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ce_in = 1'b1;
  logic sample_valid_in = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  cicp_pkg::cicp_reg_req_s reg_in;
  logic reg_ack_out;
  logic [15:0] reg_rdata_out;
  logic pv_valid_out;
  logic [15:0] pv_out;
  cicp_pkg::cicp_status_s status_out;
  logic [15:0] adc_offset_out;
  logic watchdog_en_out;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [5:0] rst_addr [8] = '{6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h20, 6'h1F, 6'h30};
  logic [15:0] rst_val [8] = '{16'h0000, 16'h2002, 16'h0FFF, 16'h0000, 16'h0000, 16'h1106,
                               16'h0000, 16'h0000};

  always #10 core_clk_in = ~core_clk_in;

  cicp_channel #(.FOUR_TO_20(1'b1), .FILTER_AVAIL(1'b1)) i_cicp_channel (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in),
    .reg_in(reg_in), .reg_ack_out(reg_ack_out), .reg_rdata_out(reg_rdata_out),
    .pv_valid_out(pv_valid_out), .pv_out(pv_out), .status_out(status_out),
    .adc_offset_out(adc_offset_out), .watchdog_en_out(watchdog_en_out));

  cicp_host_model i_cicp_host_model (
    .core_clk_in(core_clk_in), .reg_out(reg_in),
    .reg_ack_in(reg_ack_out), .reg_rdata_in(reg_rdata_out));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Run is about 125 cycles; the ceiling leaves ample margin
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("unexpected at %0t: run did not complete", $time);
      tally_and_finish();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_stat(input cicp_pkg::cicp_status_s got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: status got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    i_cicp_host_model.access(1'b1, a, d, r, ok);
    chk_bit(ok, 1'b1, "write ack");
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] r;
    logic ok;
    i_cicp_host_model.access(1'b0, a, 16'h0000, r, ok);
    chk_bit(ok, 1'b1, "read ack");
    chk_word(r, exp, "register");
  endtask

  // One sample in, one processed value and status out a cycle later
  task automatic smp(input logic [15:0] s, input logic [15:0] ep, input logic [7:0] es);
    @(posedge core_clk_in);
    #1;
    sample_valid_in = 1'b1;
    sample_in = s;
    @(posedge core_clk_in);
    #1;
    sample_valid_in = 1'b0;
    sample_in = ~s;
    chk_bit(pv_valid_out, 1'b1, "value valid");
    chk_word(pv_out, ep, "process value");
    chk_stat(status_out, es);
  endtask

  initial begin
    repeat (10) @(posedge core_clk_in);
    #1;
    resetn_in = 1'b1;
    chk_bit(watchdog_en_out, 1'b1, "watchdog");
    @(posedge core_clk_in);
    #1;
    chk_word(adc_offset_out, 16'h0000, "adc offset");
    for (int i = 0; i < 8; i++) begin
      rd(rst_addr[i], rst_val[i]);
    end
    // Locked: parameter write must not land
    wr(6'h15, 16'h0100);
    rd(6'h15, 16'h0FFF);
    wr(6'h1F, 16'h1235);
    rd(6'h1F, 16'h1235);
    // Break bit stays set in every feature value written below
    wr(6'h20, 16'h1100);
    @(posedge core_clk_in);
    #1;
    chk_bit(watchdog_en_out, 1'b0, "watchdog");
    smp(16'h0100, 16'h0100, 8'h00);
    rd(6'h00, 16'h0100);
    wr(6'h00, 16'h1234);
    rd(6'h00, 16'h0100);
    wr(6'h11, 16'hFFF0);
    wr(6'h12, 16'h2000);
    smp(16'h0100, 16'h01E0, 8'h00);
    smp(16'h1000, 16'h0FFF, 8'h42);
    rd(6'h06, 16'h0042);
    smp(16'h0000, 16'h0000, 8'h41);
    wr(6'h13, 16'h0005);
    wr(6'h14, 16'h0800);
    wr(6'h20, 16'h1102);
    smp(16'h0100, 16'h03C5, 8'h00);
    wr(6'h21, 16'hFFFF);
    wr(6'h22, 16'h0080);
    wr(6'h20, 16'h1103);
    smp(16'h0100, 16'h01E1, 8'h00);
    wr(6'h23, 16'h01E1);
    wr(6'h24, 16'h0200);
    wr(6'h20, 16'h1703);
    smp(16'h0100, 16'h01E1, 8'h1C);
    wr(6'h23, 16'h0300);
    wr(6'h24, 16'h0100);
    smp(16'h0100, 16'h01E1, 8'h24);
    wr(6'h23, 16'h0100);
    smp(16'h0100, 16'h01E1, 8'h28);
    wr(6'h20, 16'h1009);
    smp(16'h0000, 16'h8011, 8'h00);
    smp(16'h0010, 16'h8001, 8'h00);
    wr(6'h20, 16'h1111);
    smp(16'h0100, 16'h00E8, 8'h00);
    smp(16'h2000, 16'h0FF9, 8'h42);
    smp(16'h0000, 16'h0003, 8'h41);
    // Filter averages with the previous captured sample, zero here
    wr(6'h20, 16'h1900);
    smp(16'h0100, 16'h00E0, 8'h00);
    smp(16'h0100, 16'h01E0, 8'h00);
    // Enable low must freeze capture and the valid pulse
    @(posedge core_clk_in);
    #1;
    ce_in = 1'b0;
    sample_valid_in = 1'b1;
    sample_in = 16'h0300;
    @(posedge core_clk_in);
    #1;
    chk_bit(pv_valid_out, 1'b0, "frozen valid");
    sample_valid_in = 1'b0;
    ce_in = 1'b1;
    rd(6'h00, 16'h0100);
    // Relocking must protect the feature register again
    wr(6'h1F, 16'h0000);
    rd(6'h1F, 16'h0000);
    wr(6'h20, 16'h1106);
    rd(6'h20, 16'h1900);
    tally_and_finish();
  end
endmodule // current_input_channel_processing_test
